// file: core/sbcc_pkg.sv
// shared constants for the serial bcd calendar clock
package sbcc_pkg;
  // command select codes (bits 3:1 of command), rw in bit 0
  localparam logic [2:0] SEL_MODE  = 3'h0;
  localparam logic [2:0] SEL_YEAR  = 3'h1;
  localparam logic [2:0] SEL_MONTH = 3'h2;
  localparam logic [2:0] SEL_DATE  = 3'h3;
  localparam logic [2:0] SEL_WDAY  = 3'h4;
  localparam logic [2:0] SEL_HOUR  = 3'h5;
  localparam logic [2:0] SEL_MIN   = 3'h6;
  localparam logic [2:0] SEL_SEC   = 3'h7;
  localparam int CMD_BITS   = 4;
  localparam int DATA_BITS  = 8;
  localparam int WDAY_BITS  = 4;
  localparam int FRAME_BITS = 12;
  localparam int OSC_DIV    = 32768;
  localparam int OSC_OUT_BIT = 7;
  localparam int FLAG_BIT   = 3;
  // field reset values (bcd)
  localparam logic [7:0] RST_YEAR  = 8'h00;
  localparam logic [7:0] RST_MONTH = 8'h01;
  localparam logic [7:0] RST_DATE  = 8'h01;
  localparam logic [2:0] RST_WDAY  = 3'h1;
  localparam logic [7:0] RST_ZERO  = 8'h00;
  localparam logic [7:0] MAX_SEC   = 8'h59;
  localparam logic [7:0] MAX_HOUR  = 8'h23;
  localparam logic [7:0] MAX_MONTH = 8'h12;
  localparam logic [7:0] MAX_YEAR  = 8'h99;
  localparam logic [2:0] MAX_WDAY  = 3'h7;
  localparam logic [7:0] FEB       = 8'h02;
  // wishbone register offsets of the host controller
  localparam logic [3:0] ADR_CMD    = 4'h0;
  localparam logic [3:0] ADR_WDATA  = 4'h4;
  localparam logic [3:0] ADR_STATUS = 4'h8;
  localparam logic [3:0] ADR_RDATA  = 4'hc;
  localparam int CMD_GO_BIT = 8;
  localparam int LINK_DIV = 8;
  // host controller sequencer
  typedef enum logic [2:0] {SBCC_IDLE, SBCC_SETUP, SBCC_LOW, SBCC_HIGH, SBCC_HOLD,
                            SBCC_GAP} sbcc_state_t;
endpackage

// file: core/sbcc_link_if.sv
// three-wire link between host controller and calendar clock
`timescale 1ns/1ps
interface sbcc_link_if;
  logic chip_en;
  logic ser_clk;
  logic dat_host_o;
  logic dat_host_oe_b;
  logic dat_dev_o;
  logic dat_dev_oe_b;
  logic dat_line;
  // resolved wire level, pulled low when nobody drives
  assign dat_line = !dat_dev_oe_b ? dat_dev_o : (!dat_host_oe_b ? dat_host_o : 1'b0);
  modport device (input chip_en, input ser_clk, input dat_line,
                  output dat_dev_o, output dat_dev_oe_b);
  modport host (output chip_en, output ser_clk, output dat_host_o,
                output dat_host_oe_b, input dat_line);
endinterface

// file: core/sbcc_bcd_inc.sv
// one bcd counter field with wrap and carry
`timescale 1ns/1ps
module sbcc_bcd_inc #(
  parameter int W = 8
) (
  // current value and limits
  input  wire logic [W-1:0] val_i,
  input  wire logic [W-1:0] max_i,
  input  wire logic [W-1:0] min_i,
  // incremented value and wrap
  output logic [W-1:0]      nxt_o,
  output logic              wrap_o
);
  logic [7:0] v;
  logic [7:0] inc;
  // digit-wise bcd increment, wrap to min past max
  always_comb begin
    v = 8'(val_i);
    inc = (v[3:0] == 4'h9) ? {4'(v[7:4] + 4'h1), 4'h0} : {v[7:4], 4'(v[3:0] + 4'h1)};
    wrap_o = (val_i == max_i);
    nxt_o = wrap_o ? min_i : W'(inc);
  end
endmodule

// file: core/sbcc_device.sv
// calendar clock device end: counters, serial port, oscillator output
// Functional notes
// - oscillator out driven when enable set
// - chip enable low: data pin released
// - host drops chip enable between transfers
// - bits move on serial clock edges
// - serial clock low at enable edges
// - data pin input unless read selected
// - all fields packed bcd
// - month lengths and four-year leap
// - unused bits read zero
// - command: rw lsb, select above
// - select zero write loads mode byte
// - counter ranges per field
// - weekday bit 3 is low-supply flag
// - host writes only legal values
// - lsb first, sample on rising edge
// - time write stops and clears divider
// - read drives on first falling edge
// - flag sampled per second, cleared on write
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module sbcc_device #(
  parameter int DIV = sbcc_pkg::OSC_DIV
) (
  // clock and reset
  input  wire logic  ref_clk_i,
  input  wire logic  rst_b_i,
  // oscillator and supply
  input  wire logic  osc_clk_i,
  input  wire logic  low_supply_i,
  output logic       osc_out_o,
  output logic       osc_out_oe_b_o,
  // serial link
  sbcc_link_if.device link
);
  logic [2:0] ce_s_reg, ck_s_reg, dt_s_reg, osc_s_reg, sup_s_reg;
  logic ce, ck, dt, ce_d_reg, ck_d_reg, osc_d_reg;
  logic ck_rise, ck_fall, osc_rise, ce_edge;
  // three-flop synchronisers; bit 0 read only by bit 1
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ce_s_reg <= 3'h0; ck_s_reg <= 3'h0; dt_s_reg <= 3'h0;
      osc_s_reg <= 3'h0; sup_s_reg <= 3'h0;
      ce_d_reg <= 1'b0; ck_d_reg <= 1'b0; osc_d_reg <= 1'b0;
    end else begin
      ce_s_reg <= {ce_s_reg[1:0], link.chip_en};
      ck_s_reg <= {ck_s_reg[1:0], link.ser_clk};
      dt_s_reg <= {dt_s_reg[1:0], link.dat_line};
      osc_s_reg <= {osc_s_reg[1:0], osc_clk_i};
      sup_s_reg <= {sup_s_reg[1:0], low_supply_i};
      ce_d_reg <= ce_s_reg[2];
      ck_d_reg <= ck_s_reg[2];
      osc_d_reg <= osc_s_reg[2];
    end
  end
  assign ce = ce_s_reg[2];
  assign ck = ck_s_reg[2];
  assign dt = dt_s_reg[2];
  assign ck_rise = ce && ck && !ck_d_reg;
  assign ck_fall = ce && !ck && ck_d_reg;
  assign osc_rise = osc_s_reg[2] && !osc_d_reg;
  assign ce_edge = ce != ce_d_reg;

  // serial shift state
  logic [3:0]  cmd_reg;
  logic [7:0]  sh_reg;
  logic [4:0]  cnt_reg;
  logic        rd_reg, wr_reg, drv_reg;
  logic [7:0]  mode_reg;
  logic        oe_reg;
  logic        cmd_done;
  assign cmd_done = cnt_reg == 5'(sbcc_pkg::CMD_BITS);

  // counters
  logic [7:0] sec_reg, min_reg, hour_reg, date_reg, mon_reg, year_reg;
  logic [2:0] wday_reg;
  logic       flag_reg;
  logic [14:0] div_reg;
  logic        tick;
  logic        frozen;
  assign frozen = wr_reg && (cmd_reg[3:1] != sbcc_pkg::SEL_MODE);
  assign tick = osc_rise && !frozen && (div_reg == 15'(DIV - 1));

  // read value for a select, unused bits zero
  function automatic logic [7:0] rd_val(input logic [2:0] sel);
    case (sel)
      sbcc_pkg::SEL_YEAR:  rd_val = year_reg;
      sbcc_pkg::SEL_MONTH: rd_val = mon_reg;
      sbcc_pkg::SEL_DATE:  rd_val = date_reg;
      sbcc_pkg::SEL_WDAY:  rd_val = {4'h0, flag_reg, wday_reg};
      sbcc_pkg::SEL_HOUR:  rd_val = hour_reg;
      sbcc_pkg::SEL_MIN:   rd_val = min_reg;
      sbcc_pkg::SEL_SEC:   rd_val = sec_reg;
      default:             rd_val = 8'h00;
    endcase
  endfunction

  // month last day in bcd, leap every fourth year
  function automatic logic [7:0] last_day(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = (((y[7:4] * 4'd10 + y[3:0]) & 8'h03) == 8'h00);
    case (m)
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      sbcc_pkg::FEB:             last_day = leap ? 8'h29 : 8'h28;
      default:                   last_day = 8'h31;
    endcase
  endfunction

  logic [7:0] sec_n, min_n, hour_n, date_n, mon_n, year_n;
  logic       c_sec, c_min, c_hour, c_date, c_mon, c_year;
  logic [2:0] wday_n;
  logic       c_wday;
  sbcc_bcd_inc #(.W(8)) u_sec (.val_i(sec_reg), .max_i(sbcc_pkg::MAX_SEC),
    .min_i(sbcc_pkg::RST_ZERO), .nxt_o(sec_n), .wrap_o(c_sec));
  sbcc_bcd_inc #(.W(8)) u_min (.val_i(min_reg), .max_i(sbcc_pkg::MAX_SEC),
    .min_i(sbcc_pkg::RST_ZERO), .nxt_o(min_n), .wrap_o(c_min));
  sbcc_bcd_inc #(.W(8)) u_hour (.val_i(hour_reg), .max_i(sbcc_pkg::MAX_HOUR),
    .min_i(sbcc_pkg::RST_ZERO), .nxt_o(hour_n), .wrap_o(c_hour));
  sbcc_bcd_inc #(.W(8)) u_date (.val_i(date_reg), .max_i(last_day(mon_reg, year_reg)),
    .min_i(sbcc_pkg::RST_DATE), .nxt_o(date_n), .wrap_o(c_date));
  sbcc_bcd_inc #(.W(8)) u_mon (.val_i(mon_reg), .max_i(sbcc_pkg::MAX_MONTH),
    .min_i(sbcc_pkg::RST_MONTH), .nxt_o(mon_n), .wrap_o(c_mon));
  sbcc_bcd_inc #(.W(8)) u_year (.val_i(year_reg), .max_i(sbcc_pkg::MAX_YEAR),
    .min_i(sbcc_pkg::RST_YEAR), .nxt_o(year_n), .wrap_o(c_year));
  sbcc_bcd_inc #(.W(3)) u_wday (.val_i(wday_reg), .max_i(sbcc_pkg::MAX_WDAY),
    .min_i(sbcc_pkg::RST_WDAY), .nxt_o(wday_n), .wrap_o(c_wday));

  // oscillator divider: held clear during a time write, restarts once ce falls and ends the write
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_reg <= 15'h0000;
    end else if (frozen) begin
      div_reg <= 15'h0000;
    end else if (osc_rise) begin
      div_reg <= tick ? 15'h0000 : 15'(div_reg + 15'h0001);
    end
  end

  // serial receive: command then data, lsb first, last bits win
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_reg <= 4'h0; sh_reg <= 8'h00; cnt_reg <= 5'h00;
      rd_reg <= 1'b0; wr_reg <= 1'b0; drv_reg <= 1'b0;
    end else if (!ce) begin
      cnt_reg <= 5'h00; rd_reg <= 1'b0; wr_reg <= 1'b0; drv_reg <= 1'b0;
    end else if (ck_rise) begin
      if (cnt_reg < 5'(sbcc_pkg::CMD_BITS)) begin
        cmd_reg <= {dt, cmd_reg[3:1]};
        cnt_reg <= 5'(cnt_reg + 5'h01);
      end else if (wr_reg) begin
        sh_reg <= {dt, sh_reg[7:1]};
        if (cnt_reg < 5'(sbcc_pkg::FRAME_BITS)) cnt_reg <= 5'(cnt_reg + 5'h01);
      end
    end else if (cmd_done && !rd_reg && !wr_reg) begin
      if (cmd_reg[0]) begin
        wr_reg <= 1'b1;
      end else if (cmd_reg != 4'h0) begin
        rd_reg <= 1'b1;
        sh_reg <= rd_val(cmd_reg[3:1]);
      end
    end else if (rd_reg && ck_fall) begin
      if (drv_reg) sh_reg <= {1'b0, sh_reg[7:1]};
      drv_reg <= 1'b1;
    end
  end

  // data pin drive
  assign link.dat_dev_o = sh_reg[0];
  assign link.dat_dev_oe_b = !(ce && drv_reg);

  // a write lands when ce falls after at least one data bit
  logic wr_land;
  assign wr_land = ce_edge && !ce && wr_reg && cnt_reg > 5'(sbcc_pkg::CMD_BITS);

  // counters, writes at end of write frame (ce falling)
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sec_reg <= sbcc_pkg::RST_ZERO; min_reg <= sbcc_pkg::RST_ZERO;
      hour_reg <= sbcc_pkg::RST_ZERO; date_reg <= sbcc_pkg::RST_DATE;
      mon_reg <= sbcc_pkg::RST_MONTH; year_reg <= sbcc_pkg::RST_YEAR;
      wday_reg <= sbcc_pkg::RST_WDAY; mode_reg <= 8'h00; flag_reg <= 1'b0;
    end else begin
      if (wr_land) flag_reg <= 1'b0;
      // a mode write may share a cycle with a tick: the second must not be lost
      if (tick) begin
        flag_reg <= sup_s_reg[2];
        sec_reg <= sec_n;
        if (c_sec) min_reg <= min_n;
        if (c_sec && c_min) hour_reg <= hour_n;
        if (c_sec && c_min && c_hour) begin
          wday_reg <= wday_n;
          date_reg <= date_n;
          if (c_date) mon_reg <= mon_n;
          if (c_date && c_mon) year_reg <= year_n;
        end
      end
      if (wr_land) begin
        case (cmd_reg[3:1])
          sbcc_pkg::SEL_MODE:  mode_reg <= sh_reg;
          sbcc_pkg::SEL_YEAR:  year_reg <= sh_reg;
          sbcc_pkg::SEL_MONTH: mon_reg <= {3'h0, sh_reg[4:0]};
          sbcc_pkg::SEL_DATE:  date_reg <= {2'h0, sh_reg[5:0]};
          sbcc_pkg::SEL_WDAY:  wday_reg <= sh_reg[6:4]; // three bits, 6:4 of the data byte
          sbcc_pkg::SEL_HOUR:  hour_reg <= {2'h0, sh_reg[5:0]};
          sbcc_pkg::SEL_MIN:   min_reg <= {1'b0, sh_reg[6:0]};
          default:             sec_reg <= {1'b0, sh_reg[6:0]};
        endcase
      end
    end
  end

  // oscillator output pin
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) oe_reg <= 1'b0;
    else oe_reg <= mode_reg[sbcc_pkg::OSC_OUT_BIT];
  end
  assign osc_out_o = osc_s_reg[2];
  assign osc_out_oe_b_o = !oe_reg;
endmodule

// file: core/sbcc_host.sv
// host end: wishbone-controlled three-wire master
`timescale 1ns/1ps
module sbcc_host #(
  parameter int HALF = sbcc_pkg::LINK_DIV
) (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_b_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // serial link
  sbcc_link_if.host        link
);
  sbcc_pkg::sbcc_state_t st_reg;
  logic [3:0]  cmd_reg;
  logic [7:0]  wd_reg, rd_reg;
  logic [11:0] sh_reg;
  logic [3:0]  bit_reg;
  logic [7:0]  tmr_reg;
  logic        go;
  logic        wb_wr;
  logic [2:0]  dsync_reg;
  // a write lands at the edge where the master sees ack high, never earlier
  assign wb_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;
  // go when cmd written with go bit while idle
  assign go = wb_wr && wb_sel_i[1]
              && wb_adr_i == sbcc_pkg::ADR_CMD && wb_dat_i[sbcc_pkg::CMD_GO_BIT]
              && st_reg == sbcc_pkg::SBCC_IDLE;
  // wishbone ack one cycle after request, read mux
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wb_ack_o <= 1'b0; wb_dat_o <= 32'h0000_0000; wd_reg <= 8'h00;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      if (wb_wr && wb_adr_i == sbcc_pkg::ADR_WDATA && wb_sel_i[0])
        wd_reg <= wb_dat_i[7:0];
      case (wb_adr_i)
        sbcc_pkg::ADR_CMD:    wb_dat_o <= {28'h000_0000, cmd_reg};
        sbcc_pkg::ADR_WDATA:  wb_dat_o <= {24'h00_0000, wd_reg};
        sbcc_pkg::ADR_STATUS: wb_dat_o <= {31'h0, st_reg != sbcc_pkg::SBCC_IDLE};
        sbcc_pkg::ADR_RDATA:  wb_dat_o <= {24'h00_0000, rd_reg};
        default:              wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end
  // data line synchroniser
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) dsync_reg <= 3'h0;
    else dsync_reg <= {dsync_reg[1:0], link.dat_line};
  end
  // frame sequencer; clock low around every enable edge, enable low between frames
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= sbcc_pkg::SBCC_IDLE; cmd_reg <= 4'h0; sh_reg <= 12'h000;
      bit_reg <= 4'h0; tmr_reg <= 8'h00; rd_reg <= 8'h00;
      link.chip_en <= 1'b0; link.ser_clk <= 1'b0;
    end else begin
      tmr_reg <= (tmr_reg == 8'(HALF - 1)) ? 8'h00 : 8'(tmr_reg + 8'h01);
      case (st_reg)
        sbcc_pkg::SBCC_IDLE: begin
          tmr_reg <= 8'h00;
          if (go) begin
            cmd_reg <= wb_dat_i[3:0];
            sh_reg <= {wd_reg, wb_dat_i[3:0]};
            bit_reg <= 4'h0;
            st_reg <= sbcc_pkg::SBCC_SETUP;
          end
        end
        sbcc_pkg::SBCC_SETUP: begin
          link.chip_en <= 1'b1;
          if (tmr_reg == 8'(HALF - 1)) st_reg <= sbcc_pkg::SBCC_LOW;
        end
        sbcc_pkg::SBCC_LOW: if (tmr_reg == 8'(HALF - 1)) begin
          link.ser_clk <= 1'b1;
          if (bit_reg >= 4'(sbcc_pkg::CMD_BITS) && !cmd_reg[0])
            rd_reg <= {dsync_reg[2], rd_reg[7:1]};
          st_reg <= sbcc_pkg::SBCC_HIGH;
        end
        sbcc_pkg::SBCC_HIGH: if (tmr_reg == 8'(HALF - 1)) begin
          link.ser_clk <= 1'b0;
          sh_reg <= {1'b0, sh_reg[11:1]};
          bit_reg <= 4'(bit_reg + 4'h1);
          // bit_reg still holds the count before this pulse: stop after exactly 12
          st_reg <= (bit_reg == 4'(sbcc_pkg::FRAME_BITS - 1))
                    ? sbcc_pkg::SBCC_HOLD : sbcc_pkg::SBCC_LOW;
        end
        sbcc_pkg::SBCC_HOLD: if (tmr_reg == 8'(HALF - 1)) begin
          link.chip_en <= 1'b0;
          st_reg <= sbcc_pkg::SBCC_GAP;
        end
        sbcc_pkg::SBCC_GAP: if (tmr_reg == 8'(HALF - 1)) st_reg <= sbcc_pkg::SBCC_IDLE;
        default: st_reg <= sbcc_pkg::SBCC_IDLE;
      endcase
    end
  end
  assign link.dat_host_o = sh_reg[0];
  assign link.dat_host_oe_b = !(link.chip_en
                                && (bit_reg < 4'(sbcc_pkg::CMD_BITS) || cmd_reg[0]));
endmodule

// file: bench/sbcc_link_assertions.sv
// link protocol checker for the serial bcd calendar clock
`timescale 1ns/1ps
module sbcc_link_assertions (
  // clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  // link signals
  input  wire logic chip_en,
  input  wire logic ser_clk,
  input  wire logic dat_host_o,
  input  wire logic dat_host_oe_b,
  input  wire logic dat_dev_o,
  input  wire logic dat_dev_oe_b
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic [3:0] rise_cnt_reg;
  logic       clk_q_reg;
  // count serial clock rises inside one frame, cleared while idle
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rise_cnt_reg <= 4'h0;
      clk_q_reg    <= 1'b0;
    end else begin
      clk_q_reg <= ser_clk;
      if (!chip_en) rise_cnt_reg <= 4'h0;
      else if (ser_clk && !clk_q_reg) rise_cnt_reg <= rise_cnt_reg + 4'h1;
    end
  end
  // one high half of the serial clock, then low
  sequence s_high_half; ser_clk [*8] ##1 !ser_clk; endsequence
  // idle half after a frame
  sequence s_gap; !chip_en [*8]; endsequence
  // a few cycles of sync lag are allowed before the pin is released
  property p_release; !chip_en [*4] |-> dat_dev_oe_b; endproperty
  a_release: assert property (p_release) else $error("data pin driven while idle");
  property p_clk_idle; !chip_en |-> !ser_clk; endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("serial clock moved while idle");
  property p_gap; $fell(chip_en) |-> s_gap; endproperty
  a_gap: assert property (p_gap) else $error("chip enable gap too short");
  property p_half; $rose(ser_clk) |-> s_high_half; endproperty
  a_half: assert property (p_half) else $error("serial clock high half wrong");
  property p_frame_len; $fell(chip_en) |-> rise_cnt_reg == sbcc_pkg::FRAME_BITS; endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame clock count wrong");
  property p_one_driver; !dat_dev_oe_b |-> dat_host_oe_b; endproperty
  a_one_driver: assert property (p_one_driver) else $error("both ends drive data");
  property p_turn;
    $fell(dat_dev_oe_b) |-> chip_en && !ser_clk && rise_cnt_reg == sbcc_pkg::CMD_BITS;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround at wrong point");
  property p_dev_stable; ser_clk && $past(ser_clk) && !dat_dev_oe_b |-> $stable(dat_dev_o);
  endproperty
  a_dev_stable: assert property (p_dev_stable) else $error("device data moved while high");
  property p_host_stable; ser_clk && $past(ser_clk) && !dat_host_oe_b |-> $stable(dat_host_o);
  endproperty
  a_host_stable: assert property (p_host_stable) else $error("host data moved while high");
endmodule

// file: bench/serial_bcd_calendar_clock_test.sv
// self-checking bench: host and device joined over the three-wire link
`timescale 1ns/1ps
module serial_bcd_calendar_clock_test;
  localparam int DIV = 1024; // one second is 8192 clocks here
  logic        ref_clk_i;
  logic        rst_b_i;
  logic        osc_clk_i;
  logic        low_supply_i;
  logic        osc_out_o;
  logic        osc_out_oe_b_o;
  logic        wb_cyc;
  logic        wb_stb;
  logic        wb_we;
  logic [3:0]  wb_adr;
  logic [31:0] wb_wdat;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        dev_drove;
  int          fail_count;
  int          n_checks;
  logic [7:0]  rv [1:7] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00};
  logic [7:0]  wv [1:7] = '{8'h47, 8'h11, 8'h30, 8'h50, 8'h21, 8'h45, 8'h33};
  logic [7:0]  ev [1:7] = '{8'h47, 8'h11, 8'h30, 8'h05, 8'h21, 8'h45, 8'h33};
  sbcc_link_if sbcc_link_if_i ();
  sbcc_host sbcc_host_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .link(sbcc_link_if_i.host));
  sbcc_device #(.DIV(DIV)) sbcc_device_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .osc_clk_i(osc_clk_i), .low_supply_i(low_supply_i), .osc_out_o(osc_out_o),
    .osc_out_oe_b_o(osc_out_oe_b_o), .link(sbcc_link_if_i.device));
  sbcc_link_assertions sbcc_link_assertions_i (.ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i),
    .chip_en(sbcc_link_if_i.chip_en), .ser_clk(sbcc_link_if_i.ser_clk),
    .dat_host_o(sbcc_link_if_i.dat_host_o), .dat_host_oe_b(sbcc_link_if_i.dat_host_oe_b),
    .dat_dev_o(sbcc_link_if_i.dat_dev_o), .dat_dev_oe_b(sbcc_link_if_i.dat_dev_oe_b));
  // system clock and an unrelated oscillator
  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    osc_clk_i = 1'b0;
    #3;
    forever #32 osc_clk_i = ~osc_clk_i;
  end
  // remembers any device drive, so a refused command can be judged
  always @(posedge ref_clk_i) if (sbcc_link_if_i.dat_dev_oe_b === 1'b0) dev_drove <= 1'b1;
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one classic wishbone cycle; ack is read before this edge's updates land
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd);
    int n;
    @(posedge ref_clk_i);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= wd;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 100);
    if (wb_ack !== 1'b1) begin
      fail_count++;
      test_done();
    end
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  // one link frame: data, command with go, poll busy, fetch read byte
  task automatic xfer(input logic [3:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
    logic [31:0] r;
    int          n;
    wb(1'b1, sbcc_pkg::ADR_WDATA, {24'h00_0000, wd}, r);
    wb(1'b1, sbcc_pkg::ADR_CMD, {23'h00_0000, 1'b1, 4'h0, cmd}, r);
    n = 0;
    do begin
      wb(1'b0, sbcc_pkg::ADR_STATUS, 32'h0000_0000, r);
      n++;
    end while (r[0] !== 1'b0 && n < 500);
    if (r[0] !== 1'b0) begin
      fail_count++;
      test_done();
    end
    wb(1'b0, sbcc_pkg::ADR_RDATA, 32'h0000_0000, r);
    rd = r[7:0];
  endtask
  task automatic wr(input logic [2:0] sel, input logic [7:0] v);
    logic [7:0] b;
    xfer({sel, 1'b1}, v, b);
  endtask
  task automatic rdc(input logic [2:0] sel, input logic [7:0] exp);
    logic [7:0] b;
    xfer({sel, 1'b0}, 8'h00, b);
    chk($sformatf("field %0d", sel), exp, b);
  endtask
  // set a date at 23:59:59, let one second pass, read the carried result
  task automatic roll(input logic [7:0] y, m, d, input logic [2:0] w,
                      input logic [7:0] ey, em, ed, input logic [3:0] ew);
    wr(sbcc_pkg::SEL_YEAR, y);
    wr(sbcc_pkg::SEL_MONTH, m);
    wr(sbcc_pkg::SEL_DATE, d);
    wr(sbcc_pkg::SEL_WDAY, {1'b0, w, 4'h0});
    wr(sbcc_pkg::SEL_HOUR, sbcc_pkg::MAX_HOUR);
    wr(sbcc_pkg::SEL_MIN, sbcc_pkg::MAX_SEC);
    wr(sbcc_pkg::SEL_SEC, sbcc_pkg::MAX_SEC);
    repeat (9500) @(posedge ref_clk_i);
    for (int s = 5; s <= 7; s++) rdc(3'(s), 8'h00);
    rdc(sbcc_pkg::SEL_DATE, ed);
    rdc(sbcc_pkg::SEL_MONTH, em);
    rdc(sbcc_pkg::SEL_YEAR, ey);
    rdc(sbcc_pkg::SEL_WDAY, {4'h0, ew});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // watchdog well past the expected run of about 57000 clocks
  initial begin
    repeat (90000) @(posedge ref_clk_i);
    fail_count++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    logic [7:0]  b;
    rst_b_i      = 1'b0;
    low_supply_i = 1'b0;
    wb_cyc       = 1'b0;
    wb_stb       = 1'b0;
    wb_we        = 1'b0;
    wb_adr       = 4'h0;
    wb_wdat      = 32'h0000_0000;
    dev_drove    = 1'b0;
    fail_count   = 0;
    n_checks     = 0;
    repeat (10) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    for (int s = 1; s <= 7; s++) rdc(3'(s), rv[s]);
    for (int s = 1; s <= 7; s++) wr(3'(s), wv[s]);
    for (int s = 1; s <= 7; s++) rdc(3'(s), ev[s]);
    wb(1'b0, 4'h2, 32'h0000_0000, r);
    chk("unmapped", 8'h00, r[7:0]);
    @(posedge ref_clk_i);
    dev_drove <= 1'b0;
    xfer(4'h0, 8'h00, b);
    chk("refused drive", 8'h00, {7'h00, dev_drove});
    wr(sbcc_pkg::SEL_MODE, 8'h80);
    repeat (8) @(posedge ref_clk_i);
    chk("osc enable", 8'h00, {7'h00, osc_out_oe_b_o});
    // oscillator half period is four clocks, so samples four clocks apart differ
    @(negedge ref_clk_i);
    b[0] = osc_out_o;
    repeat (4) @(negedge ref_clk_i);
    chk("osc out", {7'h00, ~b[0]}, {7'h00, osc_out_o});
    wr(sbcc_pkg::SEL_MODE, 8'h00);
    repeat (8) @(posedge ref_clk_i);
    chk("osc disable", 8'h01, {7'h00, osc_out_oe_b_o});
    low_supply_i <= 1'b1;
    roll(8'h99, 8'h12, 8'h31, 3'h7, 8'h00, 8'h01, 8'h01, 4'h9);
    low_supply_i <= 1'b0;
    roll(8'h24, 8'h02, 8'h28, 3'h3, 8'h24, 8'h02, 8'h29, 4'h4);
    roll(8'h23, 8'h02, 8'h28, 3'h2, 8'h23, 8'h03, 8'h01, 4'h3);
    roll(8'h24, 8'h04, 8'h30, 3'h5, 8'h24, 8'h05, 8'h01, 4'h6);
    test_done();
  end
endmodule
